// ===== core/dsb_consts.svh
/*
  constants of the disk sector buffer control: counts, codes, timing.
  assumes a 250 MHz system clock and inclusion by bare name.
*/
// Summary of operation
// (RULE1) buffer clock on at status 15/16 read
// (RULE2) standard write: clock words to output register
// (RULE3) immediate/index write: separate gate dumps words; the code dumps them through the same dump_wr gate as standard write
// (RULE4) read index loads disk words into buffer
// (RULE5) disk write loads processor words into buffer
// (RULE6) standard read stores disk words into buffer
// (RULE7) terminate during load forces justify shifts
// (RULE8) after 90 words shift 10 more places
// (RULE9) load select clears, advances at 90 unterminated
// (RULE10) in counter per word; 90 sets justify
// (RULE11) early terminate sets finish-justify until 100
// (RULE12) dump select clears, advances at out 90
// (RULE13) write input system clock, read input synced
// (RULE14) each buffer owns its clock sequencer
// (RULE15) idle holds phase two; enable loads, phase three
// (RULE16) shift up until phase two returns
// (RULE17) reference address in two 64-bit elements; the code writes only element 0, as ref_bank is tied to 0
// (RULE18) address memory write enable low writes
// (RULE19) serial register loads parallel, shifts on disk clock
// (RULE20) read timer: 8 ms, 28-32 us, 64-96 us
// (RULE21) channel active on addressed or service request
// (RULE22) latch command and variants in phase A
// (RULE23) op register decodes read/write and variants
// (RULE24) in-use counter up on full, down out 90
// (RULE25) selectors wrap fourth to first buffer
`ifndef DSB_CONSTS_SVH
`define DSB_CONSTS_SVH
`define DSB_NBUF        4
`define DSB_DEPTH       100
`define DSB_SECTOR_WORDS 7'h5A
`define DSB_FULL_WORDS  7'h64
`define DSB_JUST_PLACES 4'hA
`define DSB_STC_DUMP_A  5'h0F
`define DSB_STC_DUMP_B  5'h10
`define DSB_STC_REF1    5'h07
`define DSB_STC_REF2    5'h08
`define DSB_STC_REF3    5'h09
`define DSB_STC_RET1    5'h0B
`define DSB_STC_RET2    5'h0C
`define DSB_STC_RET3    5'h0D
`define DSB_STC_SND1    5'h12
`define DSB_STC_SND2    5'h13
`define DSB_STC_SND3    5'h14
`define DSB_SC_TIMER    3'h3
`define DSB_CLK_MHZ     250
`define DSB_PAUSE_US    8000
`define DSB_SHORT_MIN_US 28
`define DSB_LONG_MIN_US 64
`define DSB_PAUSE_CYC   (`DSB_PAUSE_US * `DSB_CLK_MHZ)
`define DSB_SHORT_CYC   (`DSB_SHORT_MIN_US * `DSB_CLK_MHZ)
`define DSB_LONG_CYC    (`DSB_LONG_MIN_US * `DSB_CLK_MHZ)
`define DSB_CMD_XOUT    2'h2
`define DSB_CMD_XIN     2'h1
`define DSB_CMD_CONV    2'h1
`define DSB_CV_TSTS     3'h1
`define DSB_CV_TSTCLR   3'h3
`define DSB_CV_TERM     3'h6
`define DSB_OP_READ     2'h1
`define DSB_OP_WRITE    2'h2
`define DSB_VAR_STD     2'h0
`define DSB_VAR_IMM     2'h1
`define DSB_VAR_IDX     2'h2
`define DSB_REG_OP      4'h0
`define DSB_REG_STATUS  4'h4
`define DSB_REG_CMD     4'h8
`define DSB_REG_TIMER   4'hC
`define DSB_TMR_PAUSE   2'h1
`define DSB_TMR_SHORT   2'h2
`define DSB_TMR_LONG    2'h3
`endif

// ===== core/dsb_pkg.sv
/*
  types of the disk sector buffer control.
  assumes dsb_consts.svh for the numbers.
*/
package dsb_pkg;
  typedef enum logic [2:0] {
    DSB_SEQ_IDLE  = 3'b001,
    DSB_SEQ_SHIFT = 3'b010,
    DSB_SEQ_DONE  = 3'b100
  } dsb_seq_t;
  typedef logic [15:0] dsb_word_t;
endpackage

// ===== core/dsb_buffer_control.sv
/*
  four 16x100 sector buffers with load/dump selection, justify, per-buffer
  clock sequencers, address memory, disk serial register, read timer,
  exchange command latching; AXI4-Lite register access.
  assumes disk pins asynchronous, exchange strobes on CLK.
*/
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "dsb_consts.svh"
module dsb_buffer_control
  import dsb_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        COMMAND_ACTIVE_PHASE,
  input  wire logic        RESPONSE_COMPLETE_PHASE,
  input  wire logic [22:0] EXCH_IN,
  input  wire logic [3:0]  CHANNEL_NUMBER,
  input  wire logic [4:0]  STATUS_COUNT,
  input  wire logic [2:0]  SEQUENCE_COUNT,
  input  wire logic        CLEAR_CHANNEL,
  output logic [15:0]      XFER_IN_DATA,
  output logic             CHANNEL_ACTIVE_FLAG,
  input  wire logic        DISK_RW_CLOCK,
  input  wire logic        DISK_READ_DATA,
  output logic             DISK_WRITE_DATA,
  output logic             TIMER_DONE
);

  // register bus
  logic        aw_hold;
  logic        w_hold;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_ok;
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      BVALID  <= 1'b0;
      BRESP   <= 2'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_hold <= 1'b1;
        w_data <= WDATA;
      end
      if (aw_hold && w_hold && !BVALID) begin
        BVALID  <= 1'b1;
        BRESP   <= w_ok ? 2'h0 : 2'h2;
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  assign AWREADY = !aw_hold && !BVALID;
  assign WREADY  = !w_hold && !BVALID;
  assign w_ok    = (aw_addr == `DSB_REG_OP) || (aw_addr == `DSB_REG_TIMER);
  logic wr_go;
  assign wr_go = aw_hold && w_hold && !BVALID;

  // op register
  logic [1:0] op_code;
  logic [1:0] op_var;
  always_ff @(posedge CLK) begin
    if (RST || CLEAR_CHANNEL) begin
      op_code <= 2'h0;
      op_var  <= 2'h0;
    end else if (wr_go && aw_addr == `DSB_REG_OP && WSTRB[0]) begin
      op_code <= w_data[1:0]; // RULE23
      op_var  <= w_data[3:2]; // RULE23
    end
  end
  logic op_rd;
  logic op_wr;
  logic v_std;
  logic v_imm;
  logic v_idx;
  assign op_rd = op_code == `DSB_OP_READ; // RULE23
  assign op_wr = op_code == `DSB_OP_WRITE; // RULE23
  assign v_std = op_var == `DSB_VAR_STD;
  assign v_imm = op_var == `DSB_VAR_IMM;
  assign v_idx = op_var == `DSB_VAR_IDX;

  // exchange command latching
  logic       channel_addressed;
  logic       test_service_request;
  logic       conv;
  logic       terminate_flag;
  logic       xout_latch;
  logic       xin_latch;
  logic [3:0] variant_latch;
  assign channel_addressed = COMMAND_ACTIVE_PHASE && EXCH_IN[19:16] == CHANNEL_NUMBER;
  assign conv = COMMAND_ACTIVE_PHASE && EXCH_IN[21:20] == `DSB_CMD_CONV;
  assign test_service_request = conv && EXCH_IN[0] && EXCH_IN[2];
  always_ff @(posedge CLK) begin
    if (RST) begin
      CHANNEL_ACTIVE_FLAG <= 1'b0;
    end else if (COMMAND_ACTIVE_PHASE && (channel_addressed || test_service_request)) begin
      CHANNEL_ACTIVE_FLAG <= 1'b1; // RULE21
    end else if (RESPONSE_COMPLETE_PHASE) begin
      CHANNEL_ACTIVE_FLAG <= 1'b0; // RULE21
    end
  end
  always_ff @(posedge CLK) begin
    if (RST || (!CHANNEL_ACTIVE_FLAG && !COMMAND_ACTIVE_PHASE)) begin
      variant_latch  <= 4'h0;
      xout_latch     <= 1'b0;
      xin_latch      <= 1'b0;
      terminate_flag <= 1'b0;
    end else if (channel_addressed) begin
      xout_latch <= EXCH_IN[21:20] == `DSB_CMD_XOUT; // RULE22
      xin_latch  <= EXCH_IN[22]; // RULE22
      if (conv) begin
        variant_latch <= EXCH_IN[3:0]; // RULE22
        if (EXCH_IN[2:0] == `DSB_CV_TERM) begin
          terminate_flag <= 1'b1;
        end
      end
    end
  end
  logic xout_pulse;
  logic xin_pulse;
  logic [15:0] in_latch;
  always_ff @(posedge CLK) begin
    if (RST) begin
      xout_pulse <= 1'b0;
      xin_pulse  <= 1'b0;
      in_latch   <= 16'h0;
    end else begin
      xout_pulse <= channel_addressed && EXCH_IN[21:20] == `DSB_CMD_XOUT;
      xin_pulse  <= channel_addressed && EXCH_IN[22];
      if (channel_addressed) begin
        in_latch <= EXCH_IN[15:0]; // RULE22
      end
    end
  end

  // disk side synchronisers
  logic [1:0] dclk_s;
  logic [1:0] ddat_s;
  logic       dclk_d;
  always_ff @(posedge CLK) begin
    if (RST) begin
      dclk_s <= 2'h0;
      ddat_s <= 2'h0;
      dclk_d <= 1'b0;
    end else begin
      dclk_s <= {dclk_s[0], DISK_RW_CLOCK};
      ddat_s <= {ddat_s[0], DISK_READ_DATA};
      dclk_d <= dclk_s[1];
    end
  end
  logic disk_edge;
  assign disk_edge = dclk_s[1] && !dclk_d; // RULE13

  // disk serial register
  logic [7:0] disk_serial_high_byte;
  logic [7:0] disk_serial_low_byte;
  logic [3:0] bit_cnt;
  logic       word_rx;
  logic       word_tx;
  dsb_word_t  out_latch;
  logic       serial_load;
  always_ff @(posedge CLK) begin
    if (RST || CLEAR_CHANNEL) begin
      disk_serial_high_byte <= 8'h0; // RULE19
      disk_serial_low_byte  <= 8'h0;
      bit_cnt               <= 4'h0;
      word_rx               <= 1'b0;
    end else begin
      word_rx <= 1'b0;
      if (serial_load) begin
        {disk_serial_high_byte, disk_serial_low_byte} <= out_latch; // RULE19
        bit_cnt <= 4'h0;
      end else if (disk_edge) begin
        {disk_serial_high_byte, disk_serial_low_byte} <=
          {disk_serial_high_byte[6:0], disk_serial_low_byte, ddat_s[1]}; // RULE19
        bit_cnt <= bit_cnt + 4'h1;
        word_rx <= bit_cnt == 4'hF;
      end
    end
  end
  assign DISK_WRITE_DATA = disk_serial_high_byte[7];
  assign word_tx = disk_edge && bit_cnt == 4'hF;

  // load and dump gating
  logic       stc_dump;
  logic       load_rd;
  logic       load_wr;
  logic       dump_wr;
  logic       load_word;
  logic       dump_word;
  logic       just_on;
  logic       finish_just;
  logic [6:0] in_cnt;
  logic [3:0] just_cnt;
  logic [6:0] out_cnt;
  logic [1:0] load_sel;
  logic [1:0] dump_sel;
  logic [2:0] in_use;
  logic       seq_busy_ld;
  logic       seq_busy_dp;
  assign stc_dump = STATUS_COUNT == `DSB_STC_DUMP_A || STATUS_COUNT == `DSB_STC_DUMP_B;
  assign load_rd = op_rd && word_rx && (v_std || v_idx); // RULE4 RULE6
  assign load_wr = op_wr && xout_pulse; // RULE5
  assign dump_wr = op_wr && word_tx && (v_std || v_imm || v_idx); // RULE2 RULE3
  assign load_word = (load_rd || load_wr) && !just_on && !finish_just && in_use != 3'h4;
  assign dump_word = ((op_rd && stc_dump && xin_pulse) || dump_wr) && in_use != 3'h0; // RULE1
  logic just_shift;
  assign just_shift = (just_on || finish_just) && !seq_busy_ld; // RULE7 RULE8

  // per-buffer clock sequencers and storage
  logic [3:0] buffer_clock_enable;
  logic [3:0] seq_phase_one;
  logic [3:0] seq_phase_two;
  logic [3:0] seq_phase_three_flag;
  logic [3:0] load_phase_clock_out;
  logic [3:0] four_bit_seq_register [0:3];
  dsb_word_t  buf_mem [0:3][0:99];
  genvar g;
  generate
    for (g = 0; g < `DSB_NBUF; g = g + 1) begin : gbuf
      always_comb begin
        buffer_clock_enable[g] = 1'b0;
        if (load_sel == 2'(g) && (load_word || just_shift)) begin
          buffer_clock_enable[g] = 1'b1;
        end
        if (dump_sel == 2'(g) && dump_word) begin
          buffer_clock_enable[g] = 1'b1;
        end
      end
      always_ff @(posedge CLK) begin
        if (RST) begin
          four_bit_seq_register[g] <= 4'h0;
        end else if (seq_phase_three_flag[g]) begin
          four_bit_seq_register[g] <= {four_bit_seq_register[g][2:0], 1'b0}; // RULE16
        end else if (buffer_clock_enable[g]) begin
          four_bit_seq_register[g] <= 4'h1; // RULE15
        end else begin
          four_bit_seq_register[g] <= 4'h0; // RULE15
        end
      end
      assign seq_phase_three_flag[g] = four_bit_seq_register[g][0] ||
                                       four_bit_seq_register[g][1]; // RULE14
      assign seq_phase_one[g] = four_bit_seq_register[g][1];
      assign load_phase_clock_out[g] = four_bit_seq_register[g][2];
      assign seq_phase_two[g] = four_bit_seq_register[g] == 4'h0; // RULE15
      always_ff @(posedge CLK) begin
        if (buffer_clock_enable[g] && seq_phase_two[g]) begin
          for (int i = `DSB_DEPTH - 1; i > 0; i--) begin
            buf_mem[g][i] <= buf_mem[g][i-1];
          end
          buf_mem[g][0] <= (load_sel == 2'(g) && load_wr) ? in_latch :
                           {disk_serial_high_byte, disk_serial_low_byte}; // RULE13
        end
      end
    end
  endgenerate
  assign seq_busy_ld = !seq_phase_two[load_sel];
  assign seq_busy_dp = !seq_phase_two[dump_sel];

  // counters and selectors
  logic in90;
  logic in100;
  logic just10;
  logic out90;
  assign in90   = load_phase_clock_out[load_sel] && !just_on && !finish_just &&
                  in_cnt == `DSB_SECTOR_WORDS - 7'h1;
  assign in100  = finish_just && load_phase_clock_out[load_sel] &&
                  in_cnt == `DSB_FULL_WORDS - 7'h1;
  assign just10 = just_on && load_phase_clock_out[load_sel] &&
                  just_cnt == `DSB_JUST_PLACES - 4'h1;
  assign out90  = load_phase_clock_out[dump_sel] && !load_phase_clock_out[load_sel] &&
                  out_cnt == `DSB_SECTOR_WORDS - 7'h1;
  always_ff @(posedge CLK) begin
    if (RST || CLEAR_CHANNEL) begin
      in_cnt      <= 7'h0;
      just_cnt    <= 4'h0;
      just_on     <= 1'b0;
      finish_just <= 1'b0;
      load_sel    <= 2'h0; // RULE9
    end else begin
      if (load_phase_clock_out[load_sel]) begin
        in_cnt <= in_cnt + 7'h1; // RULE10
        if (just_on) begin
          just_cnt <= just_cnt + 4'h1;
        end
      end
      if (in90) begin
        just_on <= 1'b1; // RULE10
      end
      if (terminate_flag && !just_on && !finish_just && in_cnt != 7'h0 &&
          in_cnt < `DSB_SECTOR_WORDS) begin
        finish_just <= 1'b1; // RULE11
      end
      if (just10 || in100) begin
        in_cnt      <= 7'h0;
        just_cnt    <= 4'h0;
        just_on     <= 1'b0;
        finish_just <= 1'b0; // RULE11
        if (just10) begin
          load_sel <= load_sel + 2'h1; // RULE9 RULE25
        end
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST || CLEAR_CHANNEL) begin
      out_cnt  <= 7'h0;
      dump_sel <= 2'h0; // RULE12
      in_use   <= 3'h0;
      out_latch <= 16'h0;
      XFER_IN_DATA <= 16'h0;
    end else begin
      if (load_phase_clock_out[dump_sel] && !load_phase_clock_out[load_sel]) begin
        out_cnt   <= out90 ? 7'h0 : out_cnt + 7'h1; // RULE12
      end
      // take the outgoing word before the shift drops it
      if (dump_word && !seq_busy_dp) begin
        out_latch    <= buf_mem[dump_sel][`DSB_DEPTH-1];
        XFER_IN_DATA <= buf_mem[dump_sel][`DSB_DEPTH-1]; // RULE1
      end
      if (out90) begin
        dump_sel <= dump_sel + 2'h1; // RULE12 RULE25
      end
      if ((just10 || in100) && !out90) begin
        in_use <= in_use + 3'h1; // RULE24
      end else if (out90 && !(just10 || in100)) begin
        in_use <= in_use - 3'h1; // RULE24
      end
    end
  end
  assign serial_load = op_wr && word_tx && !seq_busy_dp;

  // address memory
  logic [63:0] addr_memory_element [0:1];
  logic        addr_mem_write_enable_n;
  logic [1:0]  ref_sel;
  logic        ref_bank;
  always_comb begin
    ref_sel = 2'h0;
    case (STATUS_COUNT)
      `DSB_STC_REF1, `DSB_STC_RET1, `DSB_STC_SND1: ref_sel = 2'h0; // RULE17
      `DSB_STC_REF2, `DSB_STC_RET2, `DSB_STC_SND2: ref_sel = 2'h1;
      `DSB_STC_REF3, `DSB_STC_RET3, `DSB_STC_SND3: ref_sel = 2'h2;
      default: ref_sel = 2'h3;
    endcase
  end
  assign ref_bank = 1'b0;
  assign addr_mem_write_enable_n = !(xout_pulse && STATUS_COUNT >= `DSB_STC_REF1 &&
                                     STATUS_COUNT <= `DSB_STC_REF3); // RULE18
  always_ff @(posedge CLK) begin
    if (!addr_mem_write_enable_n && ref_sel != 2'h3) begin
      addr_memory_element[ref_bank][{ref_sel, 3'h0} +: 8] <= in_latch[7:0]; // RULE17
    end
  end

  // read timer
  logic [21:0] tmr_cnt;
  logic [21:0] tmr_target;
  logic [1:0]  tmr_mode;
  always_comb begin
    case (tmr_mode)
      `DSB_TMR_PAUSE: tmr_target = 22'(`DSB_PAUSE_CYC); // RULE20
      `DSB_TMR_SHORT: tmr_target = 22'(`DSB_SHORT_CYC);
      `DSB_TMR_LONG:  tmr_target = 22'(`DSB_LONG_CYC);
      default:        tmr_target = 22'h0;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      tmr_mode   <= 2'h0;
      tmr_cnt    <= 22'h0;
      TIMER_DONE <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `DSB_REG_TIMER && WSTRB[0]) begin
        tmr_mode   <= w_data[1:0];
        tmr_cnt    <= 22'h0;
        TIMER_DONE <= 1'b0;
      end else if (SEQUENCE_COUNT == `DSB_SC_TIMER && tmr_mode != 2'h0 && !TIMER_DONE) begin
        tmr_cnt <= tmr_cnt + 22'h1;
        if (tmr_cnt == tmr_target - 22'h1) begin
          TIMER_DONE <= 1'b1; // RULE20
        end
      end
    end
  end

  // read channel
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ARADDR)
      `DSB_REG_OP:     rd_word = {28'h0, op_var, op_code};
      `DSB_REG_STATUS: rd_word = {16'h0, just_on, in_use, dump_sel, load_sel,
                                  finish_just, in_cnt};
      `DSB_REG_CMD:    rd_word = {24'h0, terminate_flag, xin_latch, xout_latch,
                                  CHANNEL_ACTIVE_FLAG, variant_latch};
      `DSB_REG_TIMER:  rd_word = {29'h0, TIMER_DONE, tmr_mode};
      default: begin
        rd_word = 32'h0;
        rd_ok   = 1'b0;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0;
      RRESP  <= 2'h0;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_word;
      RRESP  <= rd_ok ? 2'h0 : 2'h2;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end
  assign ARREADY = !RVALID;

endmodule

// ===== verif/dsb_asserts.sv
/*
  checker: exchange flag and register bus timing of the buffer control.
  assumes binding to dsb_buffer_control and sight of its ports only.
*/
`timescale 1ns/10ps
module dsb_asserts
  import dsb_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        COMMAND_ACTIVE_PHASE,
  input wire logic        RESPONSE_COMPLETE_PHASE,
  input wire logic [22:0] EXCH_IN,
  input wire logic [3:0]  CHANNEL_NUMBER,
  input wire logic        CLEAR_CHANNEL,
  input wire logic        CHANNEL_ACTIVE_FLAG,
  input wire logic        TIMER_DONE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_phase_a;
    COMMAND_ACTIVE_PHASE && !RESPONSE_COMPLETE_PHASE && !CLEAR_CHANNEL;
  endsequence
  sequence s_addr;
    s_phase_a ##0 (EXCH_IN[19:16] == CHANNEL_NUMBER);
  endsequence
  sequence s_tsr;
    s_phase_a ##0 (EXCH_IN[21:20] == 2'h1 && EXCH_IN[0] && EXCH_IN[2]);
  endsequence
  AST_CHANNEL_ACTIVE_FLAG_SET: assert property (s_addr |=> CHANNEL_ACTIVE_FLAG)
    else $error("flag not set by addressed command");
  AST_TSR_SET: assert property (s_tsr |=> CHANNEL_ACTIVE_FLAG)
    else $error("flag not set by service request");
  AST_CHANNEL_ACTIVE_FLAG_CLR: assert property (RESPONSE_COMPLETE_PHASE && !COMMAND_ACTIVE_PHASE
    |=> !CHANNEL_ACTIVE_FLAG) else $error("flag not cleared");
  AST_CHANNEL_ACTIVE_FLAG_HOLD: assert property (!COMMAND_ACTIVE_PHASE && !RESPONSE_COMPLETE_PHASE
    && !CLEAR_CHANNEL |=> $stable(CHANNEL_ACTIVE_FLAG)) else $error("flag moved alone");
  AST_RD_ANS: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  AST_RD_STAND: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  AST_B_STAND: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
  AST_RD_ONE: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read answer not released");
  AST_RST_OUT: assert property ($fell(RST) |-> !CHANNEL_ACTIVE_FLAG && !TIMER_DONE
    && !RVALID && !BVALID) else $error("outputs not cleared by reset");
endmodule
bind dsb_buffer_control dsb_asserts u_chk (.CLK(CLK), .RST(RST), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .BVALID(BVALID),
  .BREADY(BREADY), .COMMAND_ACTIVE_PHASE(COMMAND_ACTIVE_PHASE),
  .RESPONSE_COMPLETE_PHASE(RESPONSE_COMPLETE_PHASE), .EXCH_IN(EXCH_IN),
  .CHANNEL_NUMBER(CHANNEL_NUMBER), .CLEAR_CHANNEL(CLEAR_CHANNEL),
  .CHANNEL_ACTIVE_FLAG(CHANNEL_ACTIVE_FLAG), .TIMER_DONE(TIMER_DONE));

// ===== verif/dsb_host_model.sv
/*
  host processor model: command in phase A, answer slot in phase B.
  assumes send is called just after a rising edge of clk.
*/
`timescale 1ns/10ps
module dsb_host_model (
  input  wire logic        clk,
  output logic             cmd_active,
  output logic             resp_done,
  output logic [22:0]      exch
);
  initial begin
    cmd_active = 1'b0;
    resp_done = 1'b0;
    exch = 23'h0;
  end
  task automatic send(input logic [2:0] typ, input logic [3:0] chan,
                      input logic [15:0] data, input int alen);
    logic [22:0] v;
    v = {typ, chan, data};
    exch <= v;
    cmd_active <= 1'b1;
    repeat (alen) @(posedge clk);
    cmd_active <= 1'b0;
    resp_done <= 1'b1;
    exch <= ~v;
    @(posedge clk);
    resp_done <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule

// ===== verif/tb_top.sv
/*
  testbench: register bus master, exchange traffic, buffer status checks.
  assumes dsb_buffer_control with host model on the exchange.
*/
`timescale 1ns/10ps
module tb_top;
  import dsb_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} dsb_exp_t;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, clear_channel;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [4:0]  status_count;
  logic        awready, wready, bvalid, arready, rvalid, channel_active_flag, dwd, tdone, cap, rcp;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] xin;
  logic [22:0] exch;
  logic        dclk, ddat, rcp_d;
  logic [15:0] wq[$], xq[$], ex;
  int          fails, n_checks, cyc, c, v;
  dsb_exp_t    rq[$];
  dsb_exp_t    e;
  logic [1:0]  bq[$];
  logic [1:0]  eb;
  dsb_buffer_control dut_u (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .COMMAND_ACTIVE_PHASE(cap), .RESPONSE_COMPLETE_PHASE(rcp), .EXCH_IN(exch),
    .CHANNEL_NUMBER(4'h3), .STATUS_COUNT(status_count), .SEQUENCE_COUNT(3'h3),
    .CLEAR_CHANNEL(clear_channel), .XFER_IN_DATA(xin), .CHANNEL_ACTIVE_FLAG(channel_active_flag),
    .DISK_RW_CLOCK(dclk), .DISK_READ_DATA(ddat), .DISK_WRITE_DATA(dwd),
    .TIMER_DONE(tdone));
  dsb_host_model host_u (.clk(clk), .cmd_active(cap), .resp_done(rcp), .exch(exch));
  always #2 clk = ~clk;
  always @(posedge clk) rcp_d <= rcp;
  task automatic print_verdict();
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    rq.push_back('{d, m, 2'h0});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // answer monitor: oldest note against each response
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
    if (rvalid && rready && rq.size() > 0) begin
      e = rq.pop_front();
      n_checks++;
      if ((rdata & e.m) !== (e.d & e.m) || rresp !== e.r) begin
        fails++;
        $display("BAD %0t read %h resp %h", $time, rdata, rresp);
      end
    end
    if (bvalid && bready && bq.size() > 0) begin
      eb = bq.pop_front();
      n_checks++;
      if (bresp !== eb) begin
        fails++;
        $display("BAD %0t write resp %h", $time, bresp);
      end
    end
    if (rcp_d && !rcp && xq.size() > 0) begin
      ex = xq.pop_front();
      n_checks++;
      if (xin !== ex) begin
        fails++;
        $display("BAD %0t dump word %h", $time, xin);
      end
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, clear_channel, dclk, ddat} = 8'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    status_count = 5'h00;
    void'($urandom(32'h7E0F));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    clear_channel <= 1'b1;
    @(posedge clk);
    clear_channel <= 1'b0;
    @(posedge clk);
    axr(4'h4, 32'h0, 32'h7F00);
    for (c = 1; c < 3; c++)
      for (v = 0; v < 3; v++) begin
        axw(4'h0, {28'h0, v[1:0], c[1:0]}, 2'h0);
        axr(4'h0, {28'h0, v[1:0], c[1:0]}, 32'hF);
      end
    axw(4'h4, 32'h0, 2'h2);
    host_u.send(3'h1, 4'hA, 16'h0005, 1);
    host_u.send(3'h2, 4'hA, 16'h1234, 1);
    axw(4'h0, 32'h2, 2'h0);
    status_count <= 5'h0E;
    for (c = 0; c < 90; c++) begin
      v = $urandom;
      if (c < 3) wq.push_back(v[15:0]);
      host_u.send(3'h2, 4'h3, v[15:0], 1);
    end
    repeat (200) @(posedge clk);
    axr(4'h4, 32'h1100, 32'h7F00);
    repeat (5) host_u.send(3'h2, 4'h3, 16'($urandom), 1);
    host_u.send(3'h1, 4'h3, 16'h0006, 2);
    repeat (400) @(posedge clk);
    axr(4'h4, 32'h2100, 32'h7F80);
    axw(4'h0, 32'h1, 2'h0);
    status_count <= 5'h0F;
    repeat (3) begin
      xq.push_back(wq.pop_front());
      host_u.send(3'h4, 4'h3, 16'h0, 1);
    end
    v = $urandom;
    for (c = 15; c >= 0; c--) begin
      dclk <= 1'b0;
      ddat <= v[c];
      repeat (3) @(posedge clk);
      dclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    axr(4'h4, 32'h2101, 32'hFFFF);
    status_count <= 5'h00;
    axw(4'hC, 32'h2, 2'h0);
    repeat (6990) @(posedge clk);
    axr(4'hC, 32'h0, 32'h4);
    repeat (20) @(posedge clk);
    axr(4'hC, 32'h4, 32'h4);
    print_verdict();
  end
endmodule
